// ### common/iod_pkg.sv
/*
  Package for the I/O register space decoder: access kinds, address map
  constants, register data-space offsets and field masks.
  Assumes an 8-bit core with a 0x20 offset between I/O and data addresses.
*/
package iod_pkg;

  // ----------------------------------------------------------------
  // Access kinds issued by the core
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IOD_ACC_NONE,
    IOD_ACC_IO_IN,
    IOD_ACC_IO_OUT,
    IOD_ACC_DATA_LOAD,
    IOD_ACC_DATA_STORE,
    IOD_ACC_SET_BIT,
    IOD_ACC_CLEAR_BIT,
    IOD_ACC_TEST_BIT
  } iod_acc_t;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [7:0] IOD_BIT_IO_LAST  = 8'h1F;
  localparam logic [7:0] IOD_IO_LAST      = 8'h3F;
  localparam logic [7:0] IOD_DATA_OFFSET  = 8'h20;
  localparam logic [7:0] IOD_EXT_FIRST    = 8'h60;
  localparam logic [7:0] IOD_WINDOW_FIRST = 8'h4D;
  localparam logic [7:0] IOD_WINDOW_LAST  = 8'h70;
  localparam int         IOD_WINDOW_WORDS = 36;

  // ----------------------------------------------------------------
  // Register data-space addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IOD_SERIAL_PERIPH_STATUS  = 8'h4D;
  localparam logic [7:0] IOD_SERIAL_PERIPH_DATA    = 8'h4E;
  localparam logic [7:0] IOD_ANALOG_CMP_CTRL_STAT  = 8'h50;
  localparam logic [7:0] IOD_DEBUG_COMM_BYTE       = 8'h51;
  localparam logic [7:0] IOD_SLEEP_MODE_CTRL       = 8'h53;
  localparam logic [7:0] IOD_RESET_CAUSE_STATUS    = 8'h54;
  localparam logic [7:0] IOD_CORE_MISC_CTRL        = 8'h55;
  localparam logic [7:0] IOD_SELF_PROGRAM_CTRL     = 8'h57;
  localparam logic [7:0] IOD_STACK_POINTER_LOW     = 8'h5D;
  localparam logic [7:0] IOD_STACK_POINTER_HIGH    = 8'h5E;
  localparam logic [7:0] IOD_CORE_STATUS_FLAGS     = 8'h5F;
  localparam logic [7:0] IOD_WATCHDOG_CTRL_STATUS  = 8'h60;
  localparam logic [7:0] IOD_CLOCK_PRESCALE_CTRL   = 8'h61;
  localparam logic [7:0] IOD_POWER_REDUCTION_CTRL  = 8'h64;
  localparam logic [7:0] IOD_OSC_CALIBRATION       = 8'h66;
  localparam logic [7:0] IOD_PIN_CHANGE_IRQ_CTRL   = 8'h68;
  localparam logic [7:0] IOD_EXT_IRQ_SENSE_CTRL    = 8'h69;
  localparam logic [7:0] IOD_PIN_CHANGE_MASK_0     = 8'h6B;
  localparam logic [7:0] IOD_PIN_CHANGE_MASK_1     = 8'h6C;
  localparam logic [7:0] IOD_PIN_CHANGE_MASK_2     = 8'h6D;
  localparam logic [7:0] IOD_TIMER0_IRQ_MASK       = 8'h6E;
  localparam logic [7:0] IOD_TIMER1_IRQ_MASK       = 8'h6F;
  localparam logic [7:0] IOD_TIMER2_IRQ_MASK       = 8'h70;

  // ----------------------------------------------------------------
  // Field masks: implemented bits, write-one-to-clear flags, read-only
  // ----------------------------------------------------------------
  localparam logic [7:0] IOD_RESET_VALUE           = 8'h00;
  localparam logic [7:0] IOD_MASK_ALL              = 8'hFF;
  localparam logic [7:0] IOD_MASK_NONE             = 8'h00;
  localparam logic [7:0] IOD_SPS_IMPL              = 8'hC1;
  localparam logic [7:0] IOD_SPS_RO                = 8'hC0;
  localparam logic [7:0] IOD_ACS_W1C               = 8'h10;
  localparam logic [7:0] IOD_ACS_RO                = 8'h20;
  localparam logic [7:0] IOD_SMC_IMPL              = 8'h0F;
  localparam logic [7:0] IOD_RCS_IMPL              = 8'h1F;
  localparam logic [7:0] IOD_MCC_IMPL              = 8'hF3;
  localparam logic [7:0] IOD_SPM_RO                = 8'h40;
  localparam logic [7:0] IOD_WDT_W1C               = 8'h80;
  localparam logic [7:0] IOD_CPS_IMPL              = 8'h8F;
  localparam logic [7:0] IOD_PCI_IMPL              = 8'h0F;
  localparam logic [7:0] IOD_EIS_IMPL              = 8'h3F;
  localparam logic [7:0] IOD_TM0_IMPL              = 8'h07;
  localparam logic [7:0] IOD_TM1_IMPL              = 8'h27;
  localparam logic [7:0] IOD_TM2_IMPL              = 8'h07;

endpackage : iod_pkg

// ### design/iod_addr_decode.sv
/*
  Address decoder: turns an access kind and raw address into a data-space
  address and a legality flag.
  Assumes the core presents I/O addresses for I/O and bit accesses.
*/
`timescale 1ns/10ps
module iod_addr_decode
  import iod_pkg::*;
(
  // Request
  input  iod_acc_t   acc_kind,
  input  logic [7:0] acc_addr,
  // Result
  output logic [7:0] data_addr,
  output logic       legal,
  output logic       is_bit_op,
  output logic       is_write
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    data_addr = acc_addr;
    legal     = 1'b0;
    is_bit_op = 1'b0;
    is_write  = 1'b0;
    unique case (acc_kind)
      IOD_ACC_NONE: begin
        legal = 1'b0;
      end
      IOD_ACC_IO_IN, IOD_ACC_IO_OUT: begin
        legal     = (acc_addr <= IOD_IO_LAST);
        data_addr = 8'(acc_addr + IOD_DATA_OFFSET);
        is_write  = (acc_kind == IOD_ACC_IO_OUT);
      end
      IOD_ACC_DATA_LOAD, IOD_ACC_DATA_STORE: begin
        legal     = (acc_addr >= IOD_DATA_OFFSET);
        is_write  = (acc_kind == IOD_ACC_DATA_STORE);
      end
      IOD_ACC_SET_BIT, IOD_ACC_CLEAR_BIT, IOD_ACC_TEST_BIT: begin
        legal     = (acc_addr <= IOD_BIT_IO_LAST);
        data_addr = 8'(acc_addr + IOD_DATA_OFFSET);
        is_bit_op = 1'b1;
        is_write  = (acc_kind != IOD_ACC_TEST_BIT);
      end
    endcase
  end

endmodule : iod_addr_decode

// ### design/iod_reg_mem.sv
/*
  Small register store for plain read/write locations of the window.
  Assumes one write and one read port; read data is registered.
*/
`timescale 1ns/10ps
module iod_reg_mem
  import iod_pkg::*;
#(
  parameter int DEPTH = IOD_WINDOW_WORDS,
  parameter int AW    = 6
)(
  // Clock and reset
  input  logic          sys_clk,
  input  logic          sys_rst,
  // Write port
  input  logic          wr_en,
  input  logic [AW-1:0] wr_idx,
  input  logic [7:0]    wr_data,
  // Read port
  input  logic [AW-1:0] rd_idx,
  output logic [7:0]    rd_data_q
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem_q [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_depth_chk
    $error("iod_reg_mem: DEPTH too large for AW");
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= IOD_RESET_VALUE;
    end else if (wr_en && (int'(wr_idx) < DEPTH)) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  // Out-of-range index reads zero rather than X
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_q <= IOD_RESET_VALUE;
    end else begin
      rd_data_q <= (int'(rd_idx) < DEPTH) ? mem_q[rd_idx] : IOD_RESET_VALUE;
    end
  end

endmodule : iod_reg_mem

// ### design/iod_io_space.sv
/*
  I/O register space of the core: decodes I/O and load/store accesses onto the
  register window from data address 0x4D to 0x70; single-bit accesses never reach it.
  Assumes the core holds a request for one cycle, reads data one cycle later,
  and that peripheral hardware sets flags through the set inputs.
*/
`timescale 1ns/10ps
module iod_io_space
  import iod_pkg::*;
(
  // Clock and reset
  input  logic       sys_clk,
  input  logic       sys_rst,
  // Core request
  input  iod_acc_t   acc_kind,
  input  logic [7:0] acc_addr,
  input  logic [2:0] acc_bit,
  input  logic [7:0] acc_wdata,
  // Core answer
  output logic [7:0] rd_data_q,
  output logic       bit_value_q,
  output logic       rd_valid_q,
  output logic       acc_error_q,
  // Peripheral flag and status inputs
  input  logic       spi_done_set,
  input  logic       spi_collision_set,
  input  logic       cmp_event_set,
  input  logic       cmp_output,
  input  logic       wdt_event_set,
  input  logic       rww_busy,
  input  logic [4:0] reset_cause_set,
  // Register contents to peripherals
  output logic [7:0] spi_status_q,
  output logic [7:0] cmp_ctrl_q,
  output logic [7:0] reset_cause_q,
  output logic [7:0] wdt_ctrl_q,
  output logic [7:0] self_prog_q
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam int         MEM_AW = 6;
  localparam logic [7:0] ONE_HOT = 8'h01;

  function automatic logic [7:0] impl_mask(input logic [7:0] a);
    unique case (a)
      IOD_SERIAL_PERIPH_STATUS: impl_mask = IOD_SPS_IMPL;
      IOD_SERIAL_PERIPH_DATA,
      IOD_ANALOG_CMP_CTRL_STAT,
      IOD_DEBUG_COMM_BYTE,
      IOD_SELF_PROGRAM_CTRL,
      IOD_STACK_POINTER_LOW,
      IOD_STACK_POINTER_HIGH,
      IOD_CORE_STATUS_FLAGS,
      IOD_WATCHDOG_CTRL_STATUS,
      IOD_POWER_REDUCTION_CTRL,
      IOD_OSC_CALIBRATION,
      IOD_PIN_CHANGE_MASK_0,
      IOD_PIN_CHANGE_MASK_1,
      IOD_PIN_CHANGE_MASK_2:    impl_mask = IOD_MASK_ALL;
      IOD_SLEEP_MODE_CTRL:      impl_mask = IOD_SMC_IMPL;
      IOD_RESET_CAUSE_STATUS:   impl_mask = IOD_RCS_IMPL;
      IOD_CORE_MISC_CTRL:       impl_mask = IOD_MCC_IMPL;
      IOD_CLOCK_PRESCALE_CTRL:  impl_mask = IOD_CPS_IMPL;
      IOD_PIN_CHANGE_IRQ_CTRL:  impl_mask = IOD_PCI_IMPL;
      IOD_EXT_IRQ_SENSE_CTRL:   impl_mask = IOD_EIS_IMPL;
      IOD_TIMER0_IRQ_MASK:      impl_mask = IOD_TM0_IMPL;
      IOD_TIMER1_IRQ_MASK:      impl_mask = IOD_TM1_IMPL;
      IOD_TIMER2_IRQ_MASK:      impl_mask = IOD_TM2_IMPL;
      default:                  impl_mask = IOD_MASK_NONE;
    endcase
  endfunction : impl_mask

  // Flag-holding registers live in flops; the rest goes to the store
  function automatic logic is_flag_reg(input logic [7:0] a);
    is_flag_reg = (a == IOD_SERIAL_PERIPH_STATUS) || (a == IOD_ANALOG_CMP_CTRL_STAT) ||
                  (a == IOD_RESET_CAUSE_STATUS) || (a == IOD_WATCHDOG_CTRL_STATUS) ||
                  (a == IOD_SELF_PROGRAM_CTRL);
  endfunction : is_flag_reg

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [7:0] data_addr;
  logic       legal;
  logic       is_bit_op;
  logic       is_write;

  iod_addr_decode u_decode (
    .acc_kind  (acc_kind),
    .acc_addr  (acc_addr),
    .data_addr (data_addr),
    .legal     (legal),
    .is_bit_op (is_bit_op),
    .is_write  (is_write)
  );

  logic       in_window;
  logic       hit;
  logic [7:0] mask;
  logic [7:0] flag_cur;
  logic [7:0] cur_val;
  logic [7:0] wr_val;
  logic       do_write;
  logic [7:0] bit_sel;
  logic [MEM_AW-1:0] mem_idx;
  logic [7:0] mem_rdata;
  logic       was_flag_q;
  logic [7:0] flag_rd_q;
  logic       acc_q;
  logic [7:0] mask_q;
  logic [2:0] bit_q;
  logic       test_q;

  assign in_window = (data_addr >= IOD_WINDOW_FIRST) && (data_addr <= IOD_WINDOW_LAST);
  assign hit       = legal && in_window;
  assign mask      = hit ? impl_mask(data_addr) : IOD_MASK_NONE;
  assign mem_idx   = MEM_AW'(8'(data_addr - IOD_WINDOW_FIRST));
  assign bit_sel   = ONE_HOT << acc_bit;

  always_comb begin
    flag_cur = IOD_RESET_VALUE;
    unique case (data_addr)
      IOD_SERIAL_PERIPH_STATUS: flag_cur = spi_status_q;
      IOD_ANALOG_CMP_CTRL_STAT: flag_cur = cmp_ctrl_q;
      IOD_RESET_CAUSE_STATUS:   flag_cur = reset_cause_q;
      IOD_WATCHDOG_CTRL_STATUS: flag_cur = wdt_ctrl_q;
      IOD_SELF_PROGRAM_CTRL:    flag_cur = self_prog_q;
      default:                  flag_cur = IOD_RESET_VALUE;
    endcase
  end

  // No window location is bit-addressable, so bit ops never write here;
  // the read-modify-write path only serves a lower window if one is added.
  assign cur_val = flag_cur & mask;

  always_comb begin
    wr_val = acc_wdata;
    if (acc_kind == IOD_ACC_SET_BIT) begin
      wr_val = cur_val | bit_sel;
    end else if (acc_kind == IOD_ACC_CLEAR_BIT) begin
      wr_val = cur_val & ~bit_sel;
    end
  end

  assign do_write = hit && is_write;

  // ----------------------------------------------------------------
  // Plain storage
  // ----------------------------------------------------------------
  iod_reg_mem #(
    .DEPTH (IOD_WINDOW_WORDS),
    .AW    (MEM_AW)
  ) u_mem (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .wr_en     (do_write && !is_flag_reg(data_addr)),
    .wr_idx    (mem_idx),
    .wr_data   (wr_val & mask),
    .rd_idx    (mem_idx),
    .rd_data_q (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Flag registers: hardware set wins over a same-cycle clear
  // ----------------------------------------------------------------
  logic wr_sps;
  logic wr_acs;
  logic wr_rcs;
  logic wr_wdt;
  logic wr_spm;

  assign wr_sps = do_write && (data_addr == IOD_SERIAL_PERIPH_STATUS);
  assign wr_acs = do_write && (data_addr == IOD_ANALOG_CMP_CTRL_STAT);
  assign wr_rcs = do_write && (data_addr == IOD_RESET_CAUSE_STATUS);
  assign wr_wdt = do_write && (data_addr == IOD_WATCHDOG_CTRL_STATUS);
  assign wr_spm = do_write && (data_addr == IOD_SELF_PROGRAM_CTRL);

  // Done and collision flags clear by reading status; here by writing one
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      spi_status_q <= IOD_RESET_VALUE;
    end else begin
      if (wr_sps) begin
        spi_status_q <= ((spi_status_q & ~(wr_val & IOD_SPS_RO)) & IOD_SPS_RO) |
                        (wr_val & IOD_SPS_IMPL & ~IOD_SPS_RO);
      end
      if (spi_done_set)      spi_status_q[7] <= 1'b1;
      if (spi_collision_set) spi_status_q[6] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_ctrl_q <= IOD_RESET_VALUE;
    end else begin
      if (wr_acs) begin
        cmp_ctrl_q <= (wr_val & ~(IOD_ACS_W1C | IOD_ACS_RO)) |
                      (cmp_ctrl_q & IOD_ACS_W1C & ~wr_val);
      end
      cmp_ctrl_q[5] <= cmp_output;
      if (cmp_event_set) cmp_ctrl_q[4] <= 1'b1;
    end
  end

  // Cause bits set by hardware, cleared by writing zero (plain store)
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reset_cause_q <= IOD_RESET_VALUE;
    end else begin
      if (wr_rcs) reset_cause_q <= wr_val & IOD_RCS_IMPL;
      reset_cause_q[4:0] <= (wr_rcs ? wr_val[4:0] : reset_cause_q[4:0]) | reset_cause_set;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdt_ctrl_q <= IOD_RESET_VALUE;
    end else begin
      if (wr_wdt) begin
        wdt_ctrl_q <= (wr_val & ~IOD_WDT_W1C) |
                      (wdt_ctrl_q & IOD_WDT_W1C & ~wr_val);
      end
      if (wdt_event_set) wdt_ctrl_q[7] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      self_prog_q <= IOD_RESET_VALUE;
    end else begin
      if (wr_spm) self_prog_q <= wr_val & ~IOD_SPM_RO;
      self_prog_q[6] <= rww_busy;
    end
  end

  // ----------------------------------------------------------------
  // Read answer, one cycle after the request
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q       <= 1'b0;
      was_flag_q  <= 1'b0;
      flag_rd_q   <= IOD_RESET_VALUE;
      mask_q      <= IOD_MASK_NONE;
      bit_q       <= 3'h0;
      test_q      <= 1'b0;
      acc_error_q <= 1'b0;
    end else begin
      acc_q       <= legal && !is_write;
      was_flag_q  <= is_flag_reg(data_addr);
      flag_rd_q   <= cur_val;
      mask_q      <= mask;
      bit_q       <= acc_bit;
      test_q      <= legal && is_bit_op && !is_write;
      acc_error_q <= (acc_kind != IOD_ACC_NONE) && !legal;
    end
  end

  logic [7:0] rd_mux;
  assign rd_mux = was_flag_q ? flag_rd_q : (mem_rdata & mask_q);

  assign rd_data_q   = rd_mux;
  assign bit_value_q = test_q && rd_mux[bit_q];
  assign rd_valid_q  = acc_q;

endmodule : iod_io_space

// ### dv/iod_io_space_props.sv
/*
  Checker for the I/O register space: access legality, answers, aliasing
  and write-one-to-clear behaviour, seen at the top module's ports.
  Assumes one clock, an async active-high reset and one-cycle requests.
*/
`timescale 1ns/10ps
module iod_io_space_chk
  import iod_pkg::*;
(
  // Clock and reset
  input logic       sys_clk,
  input logic       sys_rst,
  // Core request and answer
  input iod_acc_t   acc_kind,
  input logic [7:0] acc_addr,
  input logic [7:0] acc_wdata,
  input logic [7:0] rd_data_q,
  input logic       bit_value_q,
  input logic       rd_valid_q,
  input logic       acc_error_q,
  // Watchdog flag
  input logic       wdt_event_set,
  input logic [7:0] wdt_ctrl_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic bit_op;
  logic io_op;
  logic data_op;
  assign bit_op  = acc_kind inside {IOD_ACC_SET_BIT, IOD_ACC_CLEAR_BIT, IOD_ACC_TEST_BIT};
  assign io_op   = acc_kind inside {IOD_ACC_IO_IN, IOD_ACC_IO_OUT};
  assign data_op = acc_kind inside {IOD_ACC_DATA_LOAD, IOD_ACC_DATA_STORE};
  sequence out_flags_s;
    acc_kind == IOD_ACC_IO_OUT && acc_addr == 8'h3F;
  endsequence
  sequence load_flags_s;
    acc_kind == IOD_ACC_DATA_LOAD && acc_addr == 8'h5F;
  endsequence
  logic w60;
  assign w60 = acc_kind == IOD_ACC_DATA_STORE && acc_addr == 8'h60;

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  bit_range_a: assert property (bit_op && acc_addr > 8'h1F |=> acc_error_q && !rd_valid_q)
    else $error("bit access above 0x1F not refused");
  bit_legal_a: assert property (bit_op && acc_addr <= 8'h1F |=> !acc_error_q)
    else $error("bit access in range refused");
  test_answer_a: assert property (acc_kind == IOD_ACC_TEST_BIT && acc_addr <= 8'h1F |=> rd_valid_q)
    else $error("bit test gave no answer");
  io_range_a: assert property (io_op && acc_addr > 8'h3F |=> acc_error_q)
    else $error("in/out above 0x3F not refused");
  io_in_a: assert property (acc_kind == IOD_ACC_IO_IN && acc_addr <= 8'h3F |=> rd_valid_q && !acc_error_q)
    else $error("in within range not answered");
  data_low_a: assert property (data_op && acc_addr < 8'h20 |=> acc_error_q)
    else $error("load/store below 0x20 not refused");
  io_alias_a: assert property (out_flags_s ##1 acc_kind == IOD_ACC_NONE ##1 load_flags_s
    |=> rd_data_q == $past(acc_wdata, 3))
    else $error("out to 0x3F not seen at data 0x5F");
  ext_load_a: assert property (acc_kind == IOD_ACC_DATA_LOAD && acc_addr == 8'h60 |=> rd_valid_q)
    else $error("load of 0x60 not answered");
  reserved_zero_a: assert property (acc_kind == IOD_ACC_DATA_LOAD && acc_addr inside {8'h4F, 8'h52, 8'h62, 8'h71}
    |=> rd_data_q == 8'h00)
    else $error("reserved location read nonzero");
  wdt_clear_a: assert property (w60 && acc_wdata[7] && !wdt_event_set |=> !wdt_ctrl_q[7])
    else $error("watchdog flag not cleared by one");
  wdt_keep_a: assert property (w60 && !acc_wdata[7] && wdt_ctrl_q[7] |=> wdt_ctrl_q[7])
    else $error("watchdog flag lost on zero write");
  answer_excl_a: assert property (rd_valid_q |-> !acc_error_q
    && $past(acc_kind) inside {IOD_ACC_IO_IN, IOD_ACC_DATA_LOAD, IOD_ACC_TEST_BIT})
    else $error("read answer without read request");
endmodule : iod_io_space_chk

bind iod_io_space iod_io_space_chk i_iod_io_space_chk (
  .sys_clk       (sys_clk),
  .sys_rst       (sys_rst),
  .acc_kind      (acc_kind),
  .acc_addr      (acc_addr),
  .acc_wdata     (acc_wdata),
  .rd_data_q     (rd_data_q),
  .bit_value_q   (bit_value_q),
  .rd_valid_q    (rd_valid_q),
  .acc_error_q   (acc_error_q),
  .wdt_event_set (wdt_event_set),
  .wdt_ctrl_q    (wdt_ctrl_q)
);

// ### dv/iod_core_model.sv
/*
  Behavioural core: issues one access at a time and collects the answer.
  Assumes the answer stands 1 ns after the edge that takes the request.
*/
`timescale 1ns/10ps
module iod_core_model
  import iod_pkg::*;
(
  // Clock
  input  logic       sys_clk,
  // Request
  output iod_acc_t   acc_kind,
  output logic [7:0] acc_addr,
  output logic [2:0] acc_bit,
  output logic [7:0] acc_wdata,
  // Answer
  input  logic [7:0] rd_data_q,
  input  logic       bit_value_q,
  input  logic       rd_valid_q,
  input  logic       acc_error_q
);
  initial begin
    acc_kind  = IOD_ACC_NONE;
    acc_addr  = 8'h00;
    acc_bit   = 3'h0;
    acc_wdata = 8'h00;
  end

  task access(input iod_acc_t k, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d,
              output logic [7:0] rd, output logic v, output logic e, output logic bv);
    @(posedge sys_clk);
    acc_kind  <= k;
    acc_addr  <= a;
    acc_bit   <= b;
    acc_wdata <= d;
    @(posedge sys_clk);
    acc_kind  <= IOD_ACC_NONE;
    // Idle lines flip so a stale value never looks valid
    acc_addr  <= ~a;
    acc_wdata <= ~d;
    #1;
    rd = rd_data_q;
    v  = rd_valid_q;
    e  = acc_error_q;
    bv = bit_value_q;
  endtask : access
endmodule : iod_core_model

// ### dv/testbench.sv
/*
  Self-checking bench for the I/O register space: register table sweep,
  then aliasing, refusals, flag clearing and a mid-run reset.
  Assumes the core model and the checker bound to the top module.
*/
`timescale 1ns/10ps
module testbench
  import iod_pkg::*;
;
  typedef struct packed { logic [7:0] addr; logic [7:0] exp; } iod_row_t;
  localparam iod_row_t ROWS [27] = '{
    '{8'h4D, 8'h01}, '{8'h4E, 8'hFF}, '{8'h4F, 8'h00}, '{8'h50, 8'hCF}, '{8'h51, 8'hFF}, '{8'h52, 8'h00},
    '{8'h53, 8'h0F}, '{8'h54, 8'h1F}, '{8'h55, 8'hF3}, '{8'h57, 8'hBF}, '{8'h5D, 8'hFF}, '{8'h5E, 8'hFF},
    '{8'h5F, 8'hFF}, '{8'h60, 8'h7F}, '{8'h61, 8'h8F}, '{8'h62, 8'h00}, '{8'h64, 8'hFF}, '{8'h66, 8'hFF},
    '{8'h68, 8'h0F}, '{8'h69, 8'h3F}, '{8'h6B, 8'hFF}, '{8'h6C, 8'hFF}, '{8'h6D, 8'hFF}, '{8'h6E, 8'h07},
    '{8'h6F, 8'h27}, '{8'h70, 8'h07}, '{8'h71, 8'h00}};
  localparam iod_acc_t BAD_KIND [7] = '{IOD_ACC_SET_BIT, IOD_ACC_CLEAR_BIT, IOD_ACC_TEST_BIT,
    IOD_ACC_IO_IN, IOD_ACC_IO_OUT, IOD_ACC_DATA_LOAD, IOD_ACC_DATA_STORE};
  localparam logic [7:0] BAD_ADDR [7] = '{8'h20, 8'h20, 8'h20, 8'h40, 8'h40, 8'h1F, 8'h1F};
  localparam iod_acc_t BIT_KIND [3] = '{IOD_ACC_SET_BIT, IOD_ACC_CLEAR_BIT, IOD_ACC_TEST_BIT};

  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  iod_acc_t   acc_kind;
  logic [7:0] acc_addr, acc_wdata, rd_data_q, rd;
  logic [2:0] acc_bit;
  logic       bit_value_q, rd_valid_q, acc_error_q, v, e, bv;
  logic       spi_done_set = 1'b0, spi_collision_set = 1'b0, cmp_event_set = 1'b0;
  logic       cmp_output = 1'b0, wdt_event_set = 1'b0, rww_busy = 1'b0;
  logic [4:0] reset_cause_set = 5'h00;
  logic [7:0] spi_status_q, cmp_ctrl_q, reset_cause_q, wdt_ctrl_q, self_prog_q;
  int         mismatches = 0, compares = 0, cycles = 0;

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  iod_core_model i_iod_core_model (.sys_clk(sys_clk), .acc_kind(acc_kind), .acc_addr(acc_addr),
    .acc_bit(acc_bit), .acc_wdata(acc_wdata), .rd_data_q(rd_data_q), .bit_value_q(bit_value_q),
    .rd_valid_q(rd_valid_q), .acc_error_q(acc_error_q));
  iod_io_space i_iod_io_space (.sys_clk(sys_clk), .sys_rst(sys_rst), .acc_kind(acc_kind),
    .acc_addr(acc_addr), .acc_bit(acc_bit), .acc_wdata(acc_wdata), .rd_data_q(rd_data_q),
    .bit_value_q(bit_value_q), .rd_valid_q(rd_valid_q), .acc_error_q(acc_error_q),
    .spi_done_set(spi_done_set), .spi_collision_set(spi_collision_set), .cmp_event_set(cmp_event_set),
    .cmp_output(cmp_output), .wdt_event_set(wdt_event_set), .rww_busy(rww_busy),
    .reset_cause_set(reset_cause_set), .spi_status_q(spi_status_q), .cmp_ctrl_q(cmp_ctrl_q),
    .reset_cause_q(reset_cause_q), .wdt_ctrl_q(wdt_ctrl_q), .self_prog_q(self_prog_q));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task give_verdict;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task run(input iod_acc_t k, input logic [7:0] a, input logic [7:0] d);
    i_iod_core_model.access(k, a, 3'h3, d, rd, v, e, bv);
  endtask : run

  // Order: spi done, spi collision, comparator, watchdog
  task pulse(input logic [3:0] f, input logic [4:0] rc);
    @(posedge sys_clk);
    {spi_done_set, spi_collision_set, cmp_event_set, wdt_event_set} <= f;
    reset_cause_set <= rc;
    @(posedge sys_clk);
    {spi_done_set, spi_collision_set, cmp_event_set, wdt_event_set} <= 4'h0;
    reset_cause_set <= 5'h00;
  endtask : pulse

  // Ceiling well above the roughly 240 cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict;
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 27; i++) begin
      run(IOD_ACC_DATA_LOAD, ROWS[i].addr, 8'h00);
      check(rd, 8'h00);
      run(IOD_ACC_DATA_STORE, ROWS[i].addr, 8'hFF);
      run(IOD_ACC_DATA_LOAD, ROWS[i].addr, 8'h00);
      check(rd, ROWS[i].exp);
    end
    $display("test register table done");
    run(IOD_ACC_IO_OUT, 8'h3F, 8'hA5);
    run(IOD_ACC_DATA_LOAD, 8'h5F, 8'h00);
    check(rd, 8'hA5);
    run(IOD_ACC_IO_IN, 8'h3F, 8'h00);
    check({7'h00, v}, 8'h01);
    run(IOD_ACC_IO_IN, 8'h30, 8'h00);
    check(rd, 8'hCF);
    $display("test io alias done");
    for (int i = 0; i < 7; i++) begin
      run(BAD_KIND[i], BAD_ADDR[i], 8'hFF);
      check({7'h00, e}, 8'h01);
    end
    for (int j = 0; j < 3; j++) begin
      run(BIT_KIND[j], 8'h1F, 8'h00);
      check({7'h00, e}, 8'h00);
    end
    check({6'h00, v, bv}, 8'h02);
    $display("test refusals done");
    pulse(4'h1, 5'h00);
    run(IOD_ACC_DATA_LOAD, 8'h60, 8'h00);
    check(rd, 8'hFF);
    run(IOD_ACC_DATA_STORE, 8'h60, 8'h00);
    run(IOD_ACC_DATA_LOAD, 8'h60, 8'h00);
    check(rd, 8'h80);
    run(IOD_ACC_DATA_STORE, 8'h60, 8'h80);
    check(wdt_ctrl_q, 8'h00);
    pulse(4'hC, 5'h00);
    run(IOD_ACC_DATA_LOAD, 8'h4D, 8'h00);
    check(rd, 8'hC1);
    run(IOD_ACC_DATA_STORE, 8'h4D, 8'h41);
    run(IOD_ACC_DATA_LOAD, 8'h4D, 8'h00);
    check(rd, 8'h81);
    check(spi_status_q, 8'h81);
    @(posedge sys_clk);
    cmp_output <= 1'b1;
    rww_busy   <= 1'b1;
    pulse(4'h2, 5'h00);
    run(IOD_ACC_DATA_LOAD, 8'h50, 8'h00);
    check(rd, 8'hFF);
    run(IOD_ACC_DATA_STORE, 8'h50, 8'h10);
    check(cmp_ctrl_q, 8'h20);
    run(IOD_ACC_DATA_LOAD, 8'h57, 8'h00);
    check(rd, 8'hFF);
    check(self_prog_q, 8'hFF);
    run(IOD_ACC_DATA_STORE, 8'h54, 8'h00);
    pulse(4'h0, 5'h0A);
    run(IOD_ACC_DATA_LOAD, 8'h54, 8'h00);
    check(rd, 8'h0A);
    check(reset_cause_q, 8'h0A);
    $display("test flags done");
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    run(IOD_ACC_DATA_LOAD, 8'h5F, 8'h00);
    check(rd, 8'h00);
    check(wdt_ctrl_q, 8'h00);
    $display("test second reset done");
    give_verdict;
  end
endmodule : testbench
